// File: common/comparator_control_pkg.sv
// Package with register map, field layout and carrier types
package comparator_control_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [31:0] CTRL_ADDR       = 32'hFFFF0444;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'h07FC;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int ON_BIT       = 10;
  localparam int NEG_SEL_LSB  = 8;
  localparam int ROUTE_LSB    = 6;
  localparam int POLARITY_BIT = 5;
  localparam int SPEED_LSB    = 3;
  localparam int HYST_BIT     = 2;
  localparam int RISE_BIT     = 1;
  localparam int FALL_BIT     = 0;

  // ***************************************************************
  // Field codes
  // ***************************************************************
  localparam logic [1:0] NEG_HALF_SUPPLY = 2'h0;
  localparam logic [1:0] NEG_ADC_THREE   = 2'h1;
  localparam logic [1:0] NEG_DAC_ONE     = 2'h2;
  localparam logic [1:0] ROUTE_PIN       = 2'h2;
  localparam logic [1:0] ROUTE_IRQ       = 2'h3;
  localparam logic [1:0] SPEED_LARGE     = 2'h0;
  localparam logic [1:0] SPEED_SMALL     = 2'h3;

  // Decoded control fields towards the analog macro
  typedef struct packed {
    logic       on;
    logic [1:0] neg_sel;
    logic [1:0] route;
    logic       polarity;
    logic [1:0] speed;
    logic       hyst;
  } analog_ctrl_t;

  // Comparator result towards its four consumers
  typedef struct packed {
    logic irq;
    logic programmable_logic_array;
    logic adc_start;
    logic pin;
  } cmp_dest_t;

endpackage

// File: rtl/comparator_edge_detect.sv
// Edge detector on the registered comparator result
`timescale 1ns/1ps
module comparator_edge_detect (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic prev;
    logic live;
    logic armed;
  } edge_state_t;

  edge_state_t state_q;
  edge_state_t state_d;

  // Track previous level; arm once prev holds a sample taken while on
  always_comb begin
    state_d       = state_q;
    state_d.prev  = level;
    state_d.live  = enable;
    state_d.armed = enable && state_q.live;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Edges are reported only when a valid previous sample exists
  assign rise = enable && state_q.armed && level && !state_q.prev;
  assign fall = enable && state_q.armed && !level && state_q.prev;

endmodule

// File: rtl/comparator_control.sv
// Comparator control register with APB slave and output routing
`timescale 1ns/1ps
module comparator_control #(
  parameter int ADDR_WIDTH = 32
) (
  input  wire logic                             CORE_CLK,
  input  wire logic                             RST_N,
  input  wire logic                             PSEL,
  input  wire logic                             PENABLE,
  input  wire logic                             PWRITE,
  input  wire logic [ADDR_WIDTH-1:0]            PADDR,
  input  wire logic [31:0]                      PWDATA,
  input  wire logic [3:0]                       PSTRB,
  output logic      [31:0]                      PRDATA,
  output logic                                  PREADY,
  output logic                                  PSLVERR,
  input  wire logic                             CMP_RAW,
  output comparator_control_pkg::analog_ctrl_t  ANALOG_CTRL,
  output logic                                  POS_MUX_TO_CMP,
  output comparator_control_pkg::cmp_dest_t     CMP_DEST
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  if (ADDR_WIDTH != 32) begin : g_bad_width
    $error("ADDR_WIDTH must be 32");
  end

  // ***************************************************************
  // State
  // ***************************************************************
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } bus_state_t;

  typedef struct packed {
    bus_state_t                          bus;
    logic [15:0]                         ctrl;
    logic [31:0]                         rdata;
    logic                                ready;
    logic                                slverr;
    logic                                level;
    comparator_control_pkg::analog_ctrl_t analog;
    logic                                pos_mux;
    comparator_control_pkg::cmp_dest_t   dest;
  } ctrl_state_t;

  ctrl_state_t state_q;
  ctrl_state_t state_d;
  logic        rise_evt;
  logic        fall_evt;

  // Address decode used by both read and write paths
  function automatic logic hit(input logic [ADDR_WIDTH-1:0] a);
    hit = (a == comparator_control_pkg::CTRL_ADDR);
  endfunction

  // Edge detection on the polarity-corrected result
  comparator_edge_detect u_edge (
    .clk    (CORE_CLK),
    .rst_n  (RST_N),
    .enable (state_q.ctrl[comparator_control_pkg::ON_BIT]),
    .level  (state_q.level),
    .rise   (rise_evt),
    .fall   (fall_evt)
  );

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  logic        acc;
  logic        wr_lo;
  logic        wr_hi;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic        out_now;
  logic        commit;

  // Bus access, register update, event flags and routing
  always_comb begin
    state_d  = state_q;
    acc      = PSEL && PENABLE && (state_q.bus == BUS_IDLE);
    // Write lands at the edge where the master sees PREADY high
    commit   = PSEL && PENABLE && PWRITE && hit(PADDR) &&
               (state_q.bus == BUS_DONE);
    wr_lo    = commit && PSTRB[0];
    wr_hi    = commit && PSTRB[1];
    wmask    = comparator_control_pkg::CTRL_WRITE_MASK;
    wval     = state_q.ctrl;
    out_now  = 1'b0;
    state_d.ready  = 1'b0;
    state_d.slverr = 1'b0;
    case (state_q.bus)
      BUS_IDLE: begin
        if (acc) begin
          state_d.bus    = BUS_DONE;
          state_d.ready  = 1'b1;
          state_d.slverr = !hit(PADDR);
          state_d.rdata  = (!PWRITE && hit(PADDR)) ?
                           {16'h0000, state_q.ctrl} : 32'h0000_0000;
        end
      end
      BUS_DONE: begin
        state_d.bus = BUS_IDLE;
      end
      default: begin
        state_d.bus = BUS_IDLE;
      end
    endcase
    // Writable fields; reserved bits stay zero
    if (wr_lo) begin
      wval[7:2] = PWDATA[7:2] & wmask[7:2];
    end
    if (wr_hi) begin
      wval[15:8] = PWDATA[15:8] & wmask[15:8];
    end
    // Write 1 clears flags, event set wins
    if (wr_lo && PWDATA[comparator_control_pkg::RISE_BIT]) begin
      wval[comparator_control_pkg::RISE_BIT] = 1'b0;
    end
    if (wr_lo && PWDATA[comparator_control_pkg::FALL_BIT]) begin
      wval[comparator_control_pkg::FALL_BIT] = 1'b0;
    end
    if (rise_evt) begin
      wval[comparator_control_pkg::RISE_BIT] = 1'b1;
    end
    if (fall_evt) begin
      wval[comparator_control_pkg::FALL_BIT] = 1'b1;
    end
    state_d.ctrl = wval;
    // Polarity-corrected result, low while off
    state_d.level = state_q.ctrl[comparator_control_pkg::ON_BIT] &&
        (CMP_RAW ^ state_q.ctrl[comparator_control_pkg::POLARITY_BIT]);
    // Analog control fields
    state_d.analog.on       = wval[comparator_control_pkg::ON_BIT];
    state_d.analog.neg_sel  =
        wval[comparator_control_pkg::NEG_SEL_LSB +: 2];
    state_d.analog.route    = wval[comparator_control_pkg::ROUTE_LSB +: 2];
    state_d.analog.polarity = wval[comparator_control_pkg::POLARITY_BIT];
    state_d.analog.speed    = wval[comparator_control_pkg::SPEED_LSB +: 2];
    state_d.analog.hyst     = wval[comparator_control_pkg::HYST_BIT];
    // Positive input takes the shared mux while on
    state_d.pos_mux = wval[comparator_control_pkg::ON_BIT];
    // Destinations
    out_now = state_q.level;
    state_d.dest.programmable_logic_array       = out_now;
    state_d.dest.adc_start = rise_evt;
    state_d.dest.pin  = out_now && (state_q.analog.route ==
                        comparator_control_pkg::ROUTE_PIN);
    state_d.dest.irq  = (state_q.analog.route ==
                        comparator_control_pkg::ROUTE_IRQ) &&
                        (wval[comparator_control_pkg::RISE_BIT] ||
                         wval[comparator_control_pkg::FALL_BIT]);
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  // All state cleared on reset
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flip-flops
  assign PRDATA         = state_q.rdata;
  assign PREADY         = state_q.ready;
  assign PSLVERR        = state_q.slverr;
  assign ANALOG_CTRL    = state_q.analog;
  assign POS_MUX_TO_CMP = state_q.pos_mux;
  assign CMP_DEST       = state_q.dest;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  a_reserved_zero: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    state_q.ctrl[15:11] == 5'h00)
    else $error("reserved bits not zero");

  a_rise_sets_flag: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    rise_evt |=> state_q.ctrl[comparator_control_pkg::RISE_BIT])
    else $error("rise flag not set");

  a_fall_sets_flag: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    fall_evt |=> state_q.ctrl[comparator_control_pkg::FALL_BIT])
    else $error("fall flag not set");

  a_rise_clear: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    (wr_lo && PWDATA[1] && !rise_evt) |=> !state_q.ctrl[1])
    else $error("rise flag not cleared");

  a_fall_clear: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    (wr_lo && PWDATA[0] && !fall_evt) |=> !state_q.ctrl[0])
    else $error("fall flag not cleared");

  a_flag_sticky: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    (state_q.ctrl[1] && !(wr_lo && PWDATA[1])) |=> state_q.ctrl[1])
    else $error("rise flag lost");

  a_enable_write: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    wr_hi |=> (ANALOG_CTRL.on == $past(PWDATA[10])))
    else $error("enable not applied");

  a_pin_route: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    CMP_DEST.pin |-> $past(state_q.analog.route) == 2'h2)
    else $error("pin driven while not routed");

  a_ready_pulse: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    PREADY |=> !PREADY)
    else $error("ready longer than one cycle");

  a_fall_sticky: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    (state_q.ctrl[0] && !(wr_lo && PWDATA[0])) |=> state_q.ctrl[0])
    else $error("fall flag lost");

  a_rise_cause: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    $rose(state_q.ctrl[1]) |-> $past(rise_evt))
    else $error("rise flag set without edge");

  a_fall_cause: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    $rose(state_q.ctrl[0]) |-> $past(fall_evt))
    else $error("fall flag set without edge");

  a_reset_ctrl: assert property (
    @(posedge CORE_CLK)
    !RST_N |=> (state_q.ctrl == comparator_control_pkg::CTRL_RESET))
    else $error("control not cleared by reset");

  a_reset_outputs: assert property (
    @(posedge CORE_CLK)
    !RST_N |=> (ANALOG_CTRL == 9'h000) && (CMP_DEST == 4'h0) &&
               !PREADY && !POS_MUX_TO_CMP)
    else $error("outputs not cleared by reset");

  a_neg_sel_write: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    wr_hi |=> (ANALOG_CTRL.neg_sel == $past(PWDATA[9:8])))
    else $error("negative input select not applied");

  a_route_write: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    wr_lo |=> (ANALOG_CTRL.route == $past(PWDATA[7:6])))
    else $error("output route not applied");

  a_polarity_write: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    wr_lo |=> (ANALOG_CTRL.polarity == $past(PWDATA[5])))
    else $error("polarity not applied");

  a_speed_write: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    wr_lo |=> (ANALOG_CTRL.speed == $past(PWDATA[4:3])))
    else $error("response speed not applied");

  a_hyst_write: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    wr_lo |=> (ANALOG_CTRL.hyst == $past(PWDATA[2])))
    else $error("hysteresis not applied");

  a_level_polarity: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    state_q.ctrl[comparator_control_pkg::ON_BIT] |=>
    (state_q.level == ($past(CMP_RAW) ^ $past(state_q.ctrl[5]))))
    else $error("level polarity wrong");

  a_level_off: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    !state_q.ctrl[comparator_control_pkg::ON_BIT] |=> !state_q.level)
    else $error("level high while off");

  a_mux_write: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    wr_hi |=> (POS_MUX_TO_CMP == $past(PWDATA[10])))
    else $error("shared mux not following enable");

  a_pla_level: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    1'b1 |=> (CMP_DEST.programmable_logic_array == $past(state_q.level)))
    else $error("logic array output wrong");

  a_adc_on_rise: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    rise_evt |=> CMP_DEST.adc_start)
    else $error("conversion start missing");

  a_adc_pulse: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    CMP_DEST.adc_start |=> !CMP_DEST.adc_start)
    else $error("conversion start longer than one cycle");

  a_irq_route: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    CMP_DEST.irq |-> ($past(state_q.analog.route) == 2'h3) &&
                     (state_q.ctrl[1:0] != 2'h0))
    else $error("interrupt without route or flag");

  a_read_data: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    (acc && !PWRITE && hit(PADDR)) |=>
    (PRDATA == {16'h0000, $past(state_q.ctrl)}))
    else $error("read data wrong");

  a_unmapped_err: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    (acc && !hit(PADDR)) |=> (PSLVERR && (PRDATA == 32'h0000_0000)))
    else $error("unmapped access not refused");

  a_unmapped_keep: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    (PSEL && PENABLE && PWRITE && !hit(PADDR) && !rise_evt && !fall_evt)
    |=> $stable(state_q.ctrl))
    else $error("unmapped write changed control");

  a_write_at_ready: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    (wr_lo || wr_hi) |-> PREADY)
    else $error("write outside ready edge");

  a_ready_answer: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    acc |=> PREADY)
    else $error("no ready after access");

endmodule

// File: testbench/test_comparator_control.sv
// Self-checking testbench for the comparator control register block
`timescale 1ns/1ps
module test_comparator_control;
  // ***************************************************************
  // Signals
  // ***************************************************************
  logic                                 CORE_CLK = 1'b0;
  logic                                 RST_N    = 1'b0;
  logic                                 PSEL     = 1'b0;
  logic                                 PENABLE  = 1'b0;
  logic                                 PWRITE   = 1'b0;
  logic                                 CMP_RAW  = 1'b1;
  logic [31:0]                          PADDR    = 32'h0;
  logic [31:0]                          PWDATA   = 32'h0;
  logic [3:0]                           PSTRB    = 4'hF;
  logic [31:0]                          PRDATA;
  logic                                 PREADY;
  logic                                 PSLVERR;
  logic                                 POS_MUX_TO_CMP;
  comparator_control_pkg::analog_ctrl_t ANALOG_CTRL;
  comparator_control_pkg::cmp_dest_t    CMP_DEST;
  int                                   n_errors   = 0;
  int                                   cmp_count  = 0;
  int                                   adc_pulses = 0;
  logic [31:0]                          rd;
  logic                                 err;
  logic [15:0]                          tbl [3] = '{16'h0084, 16'h01D8,
                                                    16'h02B8};

  comparator_control i_comparator_control (
    .CORE_CLK       (CORE_CLK),
    .RST_N          (RST_N),
    .PSEL           (PSEL),
    .PENABLE        (PENABLE),
    .PWRITE         (PWRITE),
    .PADDR          (PADDR),
    .PWDATA         (PWDATA),
    .PSTRB          (PSTRB),
    .PRDATA         (PRDATA),
    .PREADY         (PREADY),
    .PSLVERR        (PSLVERR),
    .CMP_RAW        (CMP_RAW),
    .ANALOG_CTRL    (ANALOG_CTRL),
    .POS_MUX_TO_CMP (POS_MUX_TO_CMP),
    .CMP_DEST       (CMP_DEST)
  );

  // Clock and conversion-start pulse counter
  always #10 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    if (RST_N && CMP_DEST.adc_start === 1'b1) adc_pulses++;
  end

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic conclude();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; holds the request until PREADY is sampled
  task automatic apb(input logic wr, input logic [31:0] addr, wdata);
    @(posedge CORE_CLK);
    PSEL   <= 1'b1;
    PWRITE <= wr;
    PADDR  <= addr;
    PWDATA <= wdata;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    // Values read here are those sampled at this rising edge
    @(posedge CORE_CLK);
    while (PREADY !== 1'b1) @(posedge CORE_CLK);
    rd      = PRDATA;
    err     = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] d);
    apb(1'b1, comparator_control_pkg::CTRL_ADDR, {16'h0, d});
  endtask

  task automatic rd_chk(input string what, input logic [15:0] exp);
    apb(1'b0, comparator_control_pkg::CTRL_ADDR, 32'h0);
    check(what, {16'h0, exp}, rd);
    check("slverr_mapped", 32'h0, {31'h0, err});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_reset();
    rd_chk("ctrl_reset", 16'h0000);
    check("analog_reset", 32'h0, {23'h0, ANALOG_CTRL});
    check("dest_reset", 32'h0, {28'h0, CMP_DEST});
  endtask

  task automatic t_unmapped();
    apb(1'b1, comparator_control_pkg::CTRL_ADDR + 32'h4, 32'h0400);
    check("slverr_write", 32'h1, {31'h0, err});
    apb(1'b0, comparator_control_pkg::CTRL_ADDR + 32'h4, 32'h0);
    check("slverr_read", 32'h1, {31'h0, err});
    check("unmapped_data", 32'h0, rd);
    rd_chk("ctrl_untouched", 16'h0000);
  endtask

  task automatic t_fields();
    wr(16'hFFFF);
    rd_chk("ctrl_all_ones", 16'h07FC);
    settle(2);
    check("analog_all", 32'h1FF, {23'h0, ANALOG_CTRL});
    check("pos_mux_on", 32'h1, {31'h0, POS_MUX_TO_CMP});
    // Every documented code of the select fields
    foreach (tbl[i]) begin
      wr(tbl[i]);
      rd_chk("ctrl_table", tbl[i]);
      settle(2);
      check("analog_table", {23'h0, tbl[i][10:2]},
            {23'h0, ANALOG_CTRL});
    end
    wr(16'h0000);
    settle(2);
    check("analog_off", 32'h0, {23'h0, ANALOG_CTRL});
    check("pos_mux_off", 32'h0, {31'h0, POS_MUX_TO_CMP});
  endtask

  task automatic t_edges();
    @(posedge CORE_CLK);
    CMP_RAW <= 1'b0;
    wr(16'h0480);
    rd_chk("ctrl_on_quiet", 16'h0480);
    @(posedge CORE_CLK);
    CMP_RAW <= 1'b1;
    settle(4);
    check("pin_high", 32'h1, {31'h0, CMP_DEST.pin});
    check("pla_high", 32'h1, {31'h0, CMP_DEST.programmable_logic_array});
    check("adc_one", 32'h1, adc_pulses);
    rd_chk("rise_set", 16'h0482);
    @(posedge CORE_CLK);
    CMP_RAW <= 1'b0;
    settle(4);
    check("pin_low", 32'h0, {31'h0, CMP_DEST.pin});
    rd_chk("fall_set", 16'h0483);
    wr(16'h04C0);
    rd_chk("zero_no_clear", 16'h04C3);
    settle(2);
    check("irq_flags", 32'h1, {31'h0, CMP_DEST.irq});
    wr(16'h04C2);
    rd_chk("rise_cleared", 16'h04C1);
    wr(16'h04C1);
    rd_chk("fall_cleared", 16'h04C0);
    settle(2);
    check("irq_clear", 32'h0, {31'h0, CMP_DEST.irq});
    wr(16'h04A0);
    settle(4);
    check("pla_inverted", 32'h1, {31'h0, CMP_DEST.programmable_logic_array});
    rd_chk("inverted_rise", 16'h04A2);
    check("adc_two", 32'h2, adc_pulses);
  endtask

  // Reset again in mid-run, then switch on with the result already high
  task automatic t_reset_mid();
    wr(16'h07FF);
    @(posedge CORE_CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    rd_chk("ctrl_mid_reset", 16'h0000);
    check("analog_mid_reset", 32'h0, {23'h0, ANALOG_CTRL});
    check("dest_mid_reset", 32'h0, {28'h0, CMP_DEST});
    wr(16'h0420);
    settle(4);
    rd_chk("on_no_edge", 16'h0420);
    check("pla_on_high", 32'h1, {31'h0, CMP_DEST.programmable_logic_array});
    check("adc_still_two", 32'h2, adc_pulses);
  endtask

  // ***************************************************************
  // Main sequence and watchdog
  // ***************************************************************
  initial begin
    repeat (4) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    t_reset();
    t_unmapped();
    t_fields();
    t_edges();
    t_reset_mid();
    conclude();
  end

  initial begin
    repeat (3000) @(posedge CORE_CLK);
    n_errors++;
    conclude();
  end
endmodule
